// >>> hw/port_b_consts.vh
// constants for the eight-bit port with change detection
`ifndef PORT_B_CONSTS_VH
`define PORT_B_CONSTS_VH
`define PORT_WIDTH 8
`define DIRECTION_RESET 8'hff
`define ANALOG_RESET 8'hff
`define PULLUP_RESET 8'hff
`define CHANGE_EN_RESET 8'h00
`define IRQ_ENABLE_RESET 1'b0
`define LATCH_RESET 8'h00
`define GLOBAL_PULLUP_DISABLE_RESET 1'b1
`define OPTION_PULLUP_BIT 7
`define INTERRUPT_CONTROL_FLAG_BIT 0
`define INTERRUPT_CONTROL_ENABLE_BIT 3
`endif

// >>> hw/pin_sync.v
// two-flop synchroniser for the pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 8
) (
  input wire core_clk_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;

  // no reset: pins are sampled continuously, stage1 feeds stage2 only
  always @(posedge core_clk_in) begin
    stage1_r <= async_in;
    stage2_r <= stage1_r;
  end

  assign sync_out = stage2_r;
endmodule

// >>> hw/pin_cell.v
// per-pin driver, pull-up and input qualification for one port pin
`timescale 1ns/1ps
module pin_cell (
  input wire direction_in,
  input wire latch_in,
  input wire analog_in,
  input wire pullup_en_in,
  input wire global_pullup_disable_in,
  input wire sync_level_in,
  output wire drive_out,
  output wire drive_en_out,
  output wire pullup_out,
  output wire digital_level_out
);
  // output driver works regardless of analog selection
  assign drive_en_out = ~direction_in;
  assign drive_out = latch_in;
  // pull-up only on inputs, digital pins, and with global enable
  assign pullup_out = pullup_en_in & direction_in & ~analog_in &
                      ~global_pullup_disable_in;
  assign digital_level_out = sync_level_in & ~analog_in;
endmodule

// >>> hw/port_b_gpio.v
// eight-bit bidirectional port with weak pull-ups and change interrupt
// Notes on behaviour
// - direction one tri-states the pin driver
// - direction zero drives latch onto pin
// - reads return pins, writes update latch
// - writes are read-modify-write of pin levels
// - analog-selected pins read as zero
// - analog selection leaves digital output working
// - eight individual weak pull-up enables
// - pull-up off whenever pin is output
// - power-on reset disables all pull-ups globally
// - per-pin change enables, off after power-on
// - compare enabled pins with last-read value
// - OR mismatches to set change flag
// - change interrupt can wake from sleep
// - persisting mismatch keeps setting the flag
// - last-read latch survives pin and brown-out reset
// - change during read sample still sets flag
// - analog disables input, pull-up, change detect
// - pull-ups need global disable bit cleared
`timescale 1ns/1ps
`include "port_b_consts.vh"
module port_b_gpio (
  // clock and resets
  input wire core_clk_in,
  input wire reset_in,
  input wire soft_reset_in,
  // pins
  input wire [7:0] port_b_pins_in,
  output reg [7:0] port_b_pins_out,
  output reg [7:0] port_b_pins_oe_out,
  output reg [7:0] pullup_on_out,
  // port data access
  input wire port_read_in,
  input wire port_write_in,
  input wire [7:0] write_data_in,
  input wire [7:0] write_mask_in,
  output reg [7:0] read_data_out,
  // configuration writes
  input wire direction_write_in,
  input wire [7:0] direction_data_in,
  input wire analog_write_in,
  input wire [7:0] analog_data_in,
  input wire pullup_write_in,
  input wire [7:0] pullup_data_in,
  input wire change_en_write_in,
  input wire [7:0] change_en_data_in,
  input wire option_write_in,
  input wire global_pullup_disable_in,
  input wire interrupt_control_write_in,
  input wire change_irq_enable_in,
  input wire port_change_flag_in,
  // configuration and status
  output reg [7:0] port_b_direction_out,
  output reg [7:0] analog_select_high_out,
  output reg [7:0] pullup_enable_bits_out,
  output reg [7:0] change_irq_enable_bits_out,
  output reg global_pullup_disable_out,
  output reg change_irq_enable_out,
  output reg port_change_flag_out,
  output reg irq_request_out,
  output reg wake_out
);
  // reset_in is power-on; soft_reset_in is the external-pin or brown-out reset
  wire any_reset = reset_in | soft_reset_in;

  reg [7:0] direction_r;
  reg [7:0] analog_r;
  reg [7:0] pullup_r;
  reg [7:0] change_en_r;
  reg [7:0] latch_r;
  reg [7:0] last_read_r;
  reg global_disable_r;
  reg irq_en_r;
  reg flag_r;
  reg flag_nxt;
  reg [7:0] direction_nxt;
  reg [7:0] analog_nxt;
  reg [7:0] pullup_nxt;
  reg [7:0] change_en_nxt;
  reg [7:0] latch_nxt;
  reg [7:0] last_read_nxt;
  reg [7:0] read_data_nxt;
  reg global_disable_nxt;
  reg irq_en_nxt;

  wire [7:0] sync_levels;
  wire [7:0] digital_levels;
  wire [7:0] drive;
  wire [7:0] drive_en;
  wire [7:0] pullups;

  pin_sync #(
    .WIDTH(`PORT_WIDTH)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .async_in(port_b_pins_in),
    .sync_out(sync_levels)
  );

  genvar g;
  generate
    for (g = 0; g < `PORT_WIDTH; g = g + 1) begin : g_pin
      pin_cell u_cell (
        .direction_in(direction_r[g]),
        .latch_in(latch_r[g]),
        .analog_in(analog_r[g]),
        .pullup_en_in(pullup_r[g]),
        .global_pullup_disable_in(global_disable_r),
        .sync_level_in(sync_levels[g]),
        .drive_out(drive[g]),
        .drive_en_out(drive_en[g]),
        .pullup_out(pullups[g]),
        .digital_level_out(digital_levels[g])
      );
    end
  endgenerate

  // analog pins never report a change
  wire [7:0] mismatch = (digital_levels ^ last_read_r) & change_en_r &
                        ~analog_r;
  wire any_mismatch = |mismatch;
  wire port_access = port_read_in | port_write_in;

  // configuration registers: each strobe loads its data word, otherwise it holds
  // only power-on resets them, the pin and brown-out resets keep the setup
  always @* begin
    direction_nxt = direction_r;
    if (direction_write_in) begin
      direction_nxt = direction_data_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      direction_r <= `DIRECTION_RESET;
    end else begin
      direction_r <= direction_nxt;
    end
  end

  always @* begin
    analog_nxt = analog_r;
    if (analog_write_in) begin
      analog_nxt = analog_data_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      analog_r <= `ANALOG_RESET;
    end else begin
      analog_r <= analog_nxt;
    end
  end

  always @* begin
    pullup_nxt = pullup_r;
    if (pullup_write_in) begin
      pullup_nxt = pullup_data_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      pullup_r <= `PULLUP_RESET;
    end else begin
      pullup_r <= pullup_nxt;
    end
  end

  always @* begin
    change_en_nxt = change_en_r;
    if (change_en_write_in) begin
      change_en_nxt = change_en_data_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      change_en_r <= `CHANGE_EN_RESET;
    end else begin
      change_en_r <= change_en_nxt;
    end
  end

  always @* begin
    global_disable_nxt = global_disable_r;
    if (option_write_in) begin
      global_disable_nxt = global_pullup_disable_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      global_disable_r <= `GLOBAL_PULLUP_DISABLE_RESET;
    end else begin
      global_disable_r <= global_disable_nxt;
    end
  end

  always @* begin
    irq_en_nxt = irq_en_r;
    if (interrupt_control_write_in) begin
      irq_en_nxt = change_irq_enable_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_en_r <= `IRQ_ENABLE_RESET;
    end else begin
      irq_en_r <= irq_en_nxt;
    end
  end

  // output latch: a write merges selected bits into the pin levels read back
  // an output pin with analog selected reads back zero, so a write can clear it
  always @* begin
    latch_nxt = latch_r;
    if (port_write_in) begin
      latch_nxt = (digital_levels & ~write_mask_in) |
                  (write_data_in & write_mask_in);
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      latch_r <= `LATCH_RESET;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // last-read latch: cleared only by power-on, so the other resets keep it
  // a pin moving in the same cycle as the access still mismatches the old value and sets the flag
  always @* begin
    last_read_nxt = last_read_r;
    if (port_access) begin
      last_read_nxt = digital_levels;
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      last_read_r <= `LATCH_RESET;
    end else begin
      last_read_r <= last_read_nxt;
    end
  end

  // software clears the flag by writing zero and may also set it by writing one
  wire flag_clear = interrupt_control_write_in & ~port_change_flag_in;
  wire flag_load_one = interrupt_control_write_in & port_change_flag_in;

  // flag: mismatch sets it every cycle and beats a software clear
  always @* begin
    flag_nxt = flag_r;
    if (flag_clear) begin
      flag_nxt = 1'b0;
    end
    if (flag_load_one) begin
      flag_nxt = 1'b1;
    end
    if (any_mismatch) begin
      flag_nxt = 1'b1;
    end
  end

  always @(posedge core_clk_in) begin
    if (any_reset) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // pin-side outputs come straight from flops so the pads never see a glitch
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      port_b_pins_out <= 8'h00;
      port_b_pins_oe_out <= 8'h00;
      pullup_on_out <= 8'h00;
    end else begin
      port_b_pins_out <= drive;
      port_b_pins_oe_out <= drive_en;
      pullup_on_out <= pullups;
    end
  end

  // read data holds the levels captured at the last port read
  always @* begin
    read_data_nxt = read_data_out;
    if (port_read_in) begin
      read_data_nxt = digital_levels;
    end
  end

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      read_data_out <= 8'h00;
    end else begin
      read_data_out <= read_data_nxt;
    end
  end

  // configuration mirrors lag the working registers by one clock
  always @(posedge core_clk_in) begin
    if (reset_in) begin
      port_b_direction_out <= `DIRECTION_RESET;
      analog_select_high_out <= `ANALOG_RESET;
      pullup_enable_bits_out <= `PULLUP_RESET;
      change_irq_enable_bits_out <= `CHANGE_EN_RESET;
      global_pullup_disable_out <= `GLOBAL_PULLUP_DISABLE_RESET;
      change_irq_enable_out <= `IRQ_ENABLE_RESET;
    end else begin
      port_b_direction_out <= direction_r;
      analog_select_high_out <= analog_r;
      pullup_enable_bits_out <= pullup_r;
      change_irq_enable_bits_out <= change_en_r;
      global_pullup_disable_out <= global_disable_r;
      change_irq_enable_out <= irq_en_r;
    end
  end

  // request and wake share one gate: the change interrupt enable
  // wake needs only an enabled change, not the global interrupt enable
  wire irq_nxt = flag_r & irq_en_r;
  wire wake_nxt = flag_r & irq_en_r;

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      port_change_flag_out <= 1'b0;
      irq_request_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      port_change_flag_out <= flag_r;
      irq_request_out <= irq_nxt;
      wake_out <= wake_nxt;
    end
  end
endmodule

// >>> bench/port_b_chk.sv
// assertion checker for the port block outputs
`timescale 1ns/1ps
module port_b_chk (
  // clock, resets and strobes
  input wire core_clk_in,
  input wire reset_in,
  input wire soft_reset_in,
  input wire port_read_in,
  input wire interrupt_control_write_in,
  input wire port_change_flag_in,
  // pin side
  input wire [7:0] port_b_pins_oe_out,
  input wire [7:0] pullup_on_out,
  input wire [7:0] read_data_out,
  // configuration and status
  input wire [7:0] port_b_direction_out,
  input wire [7:0] analog_select_high_out,
  input wire [7:0] pullup_enable_bits_out,
  input wire [7:0] change_irq_enable_bits_out,
  input wire global_pullup_disable_out,
  input wire change_irq_enable_out,
  input wire port_change_flag_out,
  input wire irq_request_out,
  input wire wake_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  drive_enable_a:
    assert property (port_b_pins_oe_out == ~port_b_direction_out)
    else $error("driver enable disagrees with direction");
  pullup_gate_a:
    assert property (pullup_on_out == (pullup_enable_bits_out & port_b_direction_out
      & ~analog_select_high_out & ~{8{global_pullup_disable_out}}))
    else $error("pull-up state wrong");
  irq_gate_a:
    assert property (irq_request_out == (port_change_flag_out & change_irq_enable_out))
    else $error("interrupt request not flag and enable");
  wake_follow_a:
    assert property (wake_out == irq_request_out)
    else $error("wake does not follow request");
  read_analog_a:
    assert property (port_read_in |=> (read_data_out & analog_select_high_out) == 8'h00)
    else $error("analog pin read as one");
  read_hold_a:
    assert property (!port_read_in |=> $stable(read_data_out))
    else $error("read data moved without a read");
  flag_sticky_a:
    assert property ($fell(port_change_flag_out) |->
      $past(interrupt_control_write_in & ~port_change_flag_in, 2) | $past(soft_reset_in, 2))
    else $error("change flag dropped without a clear");
  reset_values_a:
    assert property ($fell(reset_in) |-> port_b_direction_out == 8'hff
      && change_irq_enable_bits_out == 8'h00 && global_pullup_disable_out && !port_change_flag_out)
    else $error("wrong values after power-on reset");
endmodule
bind port_b_gpio port_b_chk chk_u (.*);

// >>> bench/pin_partner.sv
// far-side pin circuitry: outside drivers, pull-ups and floating pins
`timescale 1ns/1ps
module pin_partner (
  input wire core_clk_in,
  input wire [7:0] drive_in,
  input wire [7:0] drive_en_in,
  input wire [7:0] pullup_in,
  input wire [7:0] ext_val_in,
  input wire ext_en_in,
  output wire [7:0] level_out
);
  reg [7:0] float_r = 8'h5a;
  // a released pin without pull-up wanders, so a stale level never passes as a driven one
  always @(posedge core_clk_in) begin
    float_r <= ~float_r;
  end
  // outside parts only drive pins that the device has released
  assign level_out = (drive_en_in & drive_in)
    | (~drive_en_in & (ext_en_in ? ext_val_in : pullup_in | float_r));
endmodule

// >>> bench/testbench.sv
// self-checking bench for the eight-bit port with change detection
`timescale 1ns/1ps
module testbench;
  logic core_clk_in = 1'b0, reset_in, soft_reset_in, port_read_in, port_write_in;
  logic direction_write_in;
  logic analog_write_in, pullup_write_in, change_en_write_in, option_write_in, interrupt_control_write_in;
  logic global_pullup_disable_in, change_irq_enable_in, port_change_flag_in, ext_en;
  logic [7:0] write_data_in, write_mask_in, direction_data_in, analog_data_in, pullup_data_in;
  logic [7:0] change_en_data_in, ext_val, lvl, latch;
  wire [7:0] port_b_pins_in, port_b_pins_out, port_b_pins_oe_out, pullup_on_out, read_data_out;
  wire [7:0] port_b_direction_out, analog_select_high_out, pullup_enable_bits_out;
  wire [7:0] change_irq_enable_bits_out;
  wire global_pullup_disable_out, change_irq_enable_out, port_change_flag_out;
  wire irq_request_out, wake_out;
  int failures = 0;
  int samples_checked = 0;
  port_b_gpio dut_u (.*);
  pin_partner far_u (.core_clk_in, .drive_in(port_b_pins_out), .drive_en_in(port_b_pins_oe_out),
    .pullup_in(pullup_on_out), .ext_val_in(ext_val), .ext_en_in(ext_en),
    .level_out(port_b_pins_in));
  function automatic logic [7:0] pull_exp(input logic [7:0] en, dir, an, input logic dis);
    return en & dir & ~an & ~{8{dis}};
  endfunction
  task automatic chk8(input logic [7:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic idle;
    {port_read_in, port_write_in, direction_write_in, analog_write_in, pullup_write_in,
      change_en_write_in, option_write_in, interrupt_control_write_in, soft_reset_in} = 9'h000;
  endtask
  task automatic strobe;
    tick(1);
    idle;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    #20000;
    failures++;
    close_out;
  end
  initial begin
    reset_in = 1'b1;
    idle;
    {global_pullup_disable_in, change_irq_enable_in, port_change_flag_in, ext_en} = 4'h1;
    {direction_data_in, analog_data_in, pullup_data_in, change_en_data_in} = 32'h00000000;
    {write_data_in, write_mask_in, ext_val, latch} = 32'h00000000;
    void'($urandom(32'h282a55b5));
    tick(5);
    reset_in = 1'b0;
    chk8({global_pullup_disable_out, 7'h00} | change_irq_enable_bits_out, 8'h80, "reset");
    for (int i = 0; i < 24; i++) begin
      {direction_data_in, analog_data_in, pullup_data_in, ext_val} = $urandom;
      {global_pullup_disable_in, write_mask_in, write_data_in} = 17'($urandom);
      // odd rounds keep analog pins as inputs, even rounds exercise analog outputs
      if (i % 2 == 1) direction_data_in = direction_data_in | analog_data_in;
      {direction_write_in, analog_write_in, pullup_write_in, option_write_in} = 4'hf;
      strobe;
      tick(4);
      lvl = ((~direction_data_in & latch) | (direction_data_in & ext_val)) & ~analog_data_in;
      chk8(port_b_pins_oe_out, ~direction_data_in, "drive enable");
      chk8(pullup_on_out, pull_exp(pullup_data_in, direction_data_in, analog_data_in,
        global_pullup_disable_in), "pull-ups");
      chk8(port_b_direction_out, direction_data_in, "direction");
      chk8(analog_select_high_out, analog_data_in, "analog select");
      chk8(pullup_enable_bits_out, pullup_data_in, "pull-up enables");
      port_read_in = 1'b1;
      strobe;
      chk8(read_data_out, lvl, "read");
      port_write_in = 1'b1;
      strobe;
      tick(1);
      latch = (write_data_in & write_mask_in) | (lvl & ~write_mask_in);
      chk8(port_b_pins_out, latch, "write");
    end
    {direction_data_in, analog_data_in, pullup_data_in} = 24'hff00ff;
    {global_pullup_disable_in, ext_en} = 2'b00;
    {direction_write_in, analog_write_in, pullup_write_in, option_write_in} = 4'hf;
    strobe;
    tick(4);
    port_read_in = 1'b1;
    strobe;
    chk8(read_data_out, 8'hff, "released pins");
    {ext_en, ext_val} = 9'h100;
    tick(4);
    port_read_in = 1'b1;
    strobe;
    {change_en_data_in, change_irq_enable_in, port_change_flag_in} = 10'h006;
    {change_en_write_in, interrupt_control_write_in} = 2'b11;
    strobe;
    tick(4);
    ext_val = 8'h02;
    tick(6);
    chk8({7'h00, port_change_flag_out}, 8'h00, "pin not enabled");
    chk8(change_irq_enable_bits_out, change_en_data_in, "change enables");
    chk8({7'h00, change_irq_enable_out}, 8'h01, "change irq enable");
    ext_val = 8'h03;
    tick(6);
    chk8({5'h00, port_change_flag_out, irq_request_out, wake_out}, 8'h07, "change");
    interrupt_control_write_in = 1'b1;
    strobe;
    tick(1);
    chk8({7'h00, port_change_flag_out}, 8'h01, "clear during mismatch");
    soft_reset_in = 1'b1;
    strobe;
    tick(4);
    chk8({7'h00, port_change_flag_out}, 8'h01, "soft reset");
    port_read_in = 1'b1;
    strobe;
    tick(2);
    interrupt_control_write_in = 1'b1;
    strobe;
    tick(4);
    chk8({5'h00, port_change_flag_out, irq_request_out, wake_out}, 8'h00, "cleared");
    soft_reset_in = 1'b1;
    strobe;
    tick(4);
    chk8({7'h00, port_change_flag_out}, 8'h00, "last read kept");
    close_out;
  end
endmodule
